// ### bench/bp_match_sva.sv
`timescale 1ns/1ps
module bp_match_sva import bp_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic accValid,
  input acc_kind_t accKind,
  input wire logic [ADDR_W-1:0] accAddr,
  input wire logic [BYTES_W-1:0] accBytes,
  input wire logic taskSwitch,
  input wire logic dbgExcReq,
  input wire logic dbgExcBefore,
  input wire logic [NUM_BP-1:0] dbgExcHits,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_req_hits: assert property (dbgExcReq == (dbgExcHits != 4'h0))
    else $error("request and hit vector disagree");
  chk_req_cause: assert property (dbgExcReq |-> $past(accValid))
    else $error("request without an access");
  chk_no_access: assert property (!accValid |=> !dbgExcReq)
    else $error("request after idle cycle");
  chk_before_exec: assert property (dbgExcReq |->
    dbgExcBefore == ($past(accKind) == ACC_EXEC))
    else $error("wrong before flag");
  chk_zero_bytes: assert property (accValid && accBytes == 4'h0
    |=> !dbgExcReq)
    else $error("empty access matched");
  chk_rd_idle: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data outside read cycle");
  chk_local_clear: assert property (taskSwitch ##1
    (regRd && regAddr == OFS_CTRL)
    |=> (regRdData & 32'h00000055) == 32'h0)
    else $error("local enable survived task switch");
  chk_clr_reads: assert property (regRd && regAddr == OFS_EVT_CLR
    |=> regRdData == 32'h0)
    else $error("clear register read not zero");

  cover property (dbgExcReq && dbgExcBefore);
  cover property (dbgExcReq && !dbgExcBefore);
  cover property (irq);
endmodule

bind breakpoint_address_match bp_match_sva u_bp_match_sva (
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .accValid(accValid), .accKind(accKind), .accAddr(accAddr),
  .accBytes(accBytes), .taskSwitch(taskSwitch), .dbgExcReq(dbgExcReq),
  .dbgExcBefore(dbgExcBefore), .dbgExcHits(dbgExcHits), .irq(irq));

// ### bench/cpu_access_model.sv
`timescale 1ns/1ps
module cpu_access_model import bp_pkg::*; (
  input wire logic clk,
  output logic accValid,
  output acc_kind_t accKind,
  output logic [ADDR_W-1:0] accAddr,
  output logic [BYTES_W-1:0] accBytes
);
  initial begin
    accValid = 1'h0;
    accKind = ACC_EXEC;
    accAddr = 64'h0;
    accBytes = 4'h0;
  end

  // ------------------------------------------------------------
  // One access, then the address lines toggle
  // ------------------------------------------------------------
  task automatic issue(input acc_kind_t k, input logic [ADDR_W-1:0] a,
                       input logic [BYTES_W-1:0] b);
    @(posedge clk);
    accValid <= 1'h1;
    accKind <= k;
    accAddr <= a;
    accBytes <= b;
    @(posedge clk);
    accValid <= 1'h0;
    accAddr <= ~a;
  endtask
endmodule

// ### bench/test_breakpoint_address_match.sv
`timescale 1ns/1ps
module test_breakpoint_address_match import bp_pkg::*;;
  logic clk, rst_n, regWr, regRd, accValid, taskSwitch;
  logic dbgExcReq, dbgExcBefore, irq;
  logic [REG_AW-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData;
  acc_kind_t accKind;
  logic [ADDR_W-1:0] accAddr;
  logic [BYTES_W-1:0] accBytes;
  logic [NUM_BP-1:0] dbgExcHits;
  int fail_count = 0;
  int checks = 0;
  logic [ADDR_W-1:0] ta[6] = '{64'heffb, 64'heffe, 64'heffe, 64'hf000,
                               64'hf001, 64'hf005};
  logic [3:0] tb[6] = '{4'h8, 4'h2, 4'h4, 4'h1, 4'h2, 4'h4};
  logic [3:0] th[6] = '{4'h5, 4'h0, 4'h5, 4'h5, 4'h4, 4'h6};

  breakpoint_address_match u_breakpoint_address_match (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .accValid(accValid), .accKind(accKind), .accAddr(accAddr),
    .accBytes(accBytes), .taskSwitch(taskSwitch), .dbgExcReq(dbgExcReq),
    .dbgExcBefore(dbgExcBefore), .dbgExcHits(dbgExcHits), .irq(irq));
  cpu_access_model u_cpu_access_model (.clk(clk), .accValid(accValid),
    .accKind(accKind), .accAddr(accAddr), .accBytes(accBytes));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic test_done();
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string n);
    @(posedge clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'h0;
    #1 chk(n, e, regRdData);
  endtask
  task automatic acc(input acc_kind_t k, input logic [63:0] a,
                     input logic [3:0] b, input logic [3:0] eh);
    u_cpu_access_model.issue(k, a, b);
    #1 chk("hits", {28'h0, eh}, {28'h0, dbgExcHits});
    chk("request", {31'h0, eh != 4'h0}, {31'h0, dbgExcReq});
    if (eh != 4'h0) begin
      // Before flag only with a request
      chk("before", {31'h0, k == ACC_EXEC}, {31'h0, dbgExcBefore});
    end
  endtask
  function automatic logic [3:0] expHit(int t, int d, acc_kind_t k);
    case (t)
      0: return {3'h0, k == ACC_EXEC};
      1: return {3'h0, k == ACC_MEM_WRITE};
      2: return {3'h0, d == 1 && (k == ACC_IO_READ || k == ACC_IO_WRITE)};
      default: return {3'h0, k == ACC_MEM_READ || k == ACC_MEM_WRITE};
    endcase
  endfunction

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #1000000;
    fail_count++;
    test_done();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    regAddr = 8'h0;
    regWrData = 32'h0;
    regWr = 1'h0;
    regRd = 1'h0;
    taskSwitch = 1'h0;
    rst_n = 1'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    rd(OFS_CTRL, 32'h0, "ctrl");
    rd(8'h3c, 32'h0, "unmapped");
    wr(OFS_ADDR_BASE, 32'hf000);
    wr(8'h08, 32'hf004);
    wr(8'h10, 32'hf000);
    wr(8'h1c, 32'h1);
    rd(8'h10, 32'hf000, "addr2");
    rd(8'h14, 32'h0, "addr2 high");
    rd(8'h1c, 32'h1, "addr3 high");
    wr(OFS_CTRL, 32'hffffffff);
    rd(OFS_CTRL, 32'hffff00ff, "ctrl mask");
    wr(OFS_MODE, 32'h2);
    rd(OFS_MODE, 32'h2, "mode");
    wr(OFS_CTRL, 32'h0bf30019);
    for (int i = 0; i < 6; i++) begin
      acc(ACC_MEM_READ, ta[i], tb[i], th[i]);
    end
    acc(ACC_MEM_READ, 64'hf000, 4'h0, 4'h0);
    acc(ACC_EXEC, 64'hf000, 4'h1, 4'h0);
    rd(OFS_STAT, 32'h7, "hit flags");
    wr(OFS_STAT, 32'h0);
    rd(OFS_STAT, 32'h0, "hit flags cleared");
    wr(OFS_MODE, 32'h0);
    acc(ACC_MEM_READ, 64'hf001, 4'h2, 4'h0);
    wr(OFS_CTRL, 32'h00070001);
    acc(ACC_MEM_WRITE, 64'hf001, 4'h1, 4'h1);
    acc(ACC_MEM_READ, 64'hf002, 4'h1, 4'h0);
    for (int t = 0; t < 4; t++) begin
      wr(OFS_CTRL, 32'h1 | (t << 16));
      for (int d = 0; d < 2; d++) begin
        wr(OFS_MODE, d);
        for (int k = 0; k < 5; k++) begin
          acc(acc_kind_t'(k), 64'hf000, 4'h1,
              expHit(t, d, acc_kind_t'(k)));
        end
      end
    end
    rd(OFS_EVT_STAT, 32'h1, "event status");
    chk("irq", 32'h0, {31'h0, irq});
    wr(OFS_EVT_EN, 32'h1);
    rd(OFS_EVT_EN, 32'h1, "event enable");
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFS_CTRL, 32'h7);
    @(posedge clk);
    taskSwitch <= 1'h1;
    @(posedge clk);
    taskSwitch <= 1'h0;
    regRd <= 1'h1;
    regAddr <= OFS_CTRL;
    @(posedge clk);
    regRd <= 1'h0;
    #1 chk("ctrl after switch", 32'h2, regRdData);
    acc(ACC_EXEC, 64'hf000, 4'h1, 4'h1);
    acc(ACC_EXEC, 64'hf004, 4'h1, 4'h0);
    rd(OFS_EVT_STAT, 32'h3, "event status");
    rd(OFS_EVT_CLR, 32'h0, "clear read");
    wr(OFS_EVT_CLR, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk("irq", 32'h0, {31'h0, irq});
    rd(OFS_EVT_STAT, 32'h2, "event status");
    test_done();
  end
endmodule

// ### rtl/bp_comparator.sv
`timescale 1ns/1ps
module bp_comparator import bp_pkg::*; (
  input wire logic enabled,
  input wire logic [ADDR_W-1:0] bpAddr,
  input wire logic [1:0] accessType,
  input wire logic [1:0] matchLength,
  input wire logic debugExtEn,
  input wire logic longMode,
  input wire logic accValid,
  input acc_kind_t accKind,
  input wire logic [ADDR_W-1:0] accAddr,
  input wire logic [BYTES_W-1:0] accBytes,
  output logic hit
);

  logic kindOk;
  logic lenOk;
  logic [ADDR_W-1:0] mask;
  logic [ADDR_W-1:0] rangeLo;
  logic [ADDR_W-1:0] rangeHi;
  logic [ADDR_W:0] accHi;
  logic overlap;

  always_comb begin
    kindOk = 1'h0;
    unique case (accessType)
      TYPE_EXEC: kindOk = (accKind == ACC_EXEC);
      TYPE_WRITE: kindOk = (accKind == ACC_MEM_WRITE);
      TYPE_IO: kindOk = debugExtEn &&
        (accKind == ACC_IO_READ || accKind == ACC_IO_WRITE);
      TYPE_RW: kindOk = (accKind == ACC_MEM_READ ||
        accKind == ACC_MEM_WRITE);
    endcase
    lenOk = 1'h1;
    mask = MASK_1;
    unique case (matchLength)
      LEN_1: mask = MASK_1;
      LEN_2: mask = MASK_2;
      LEN_4: mask = MASK_4;
      LEN_8: begin
        mask = MASK_8;
        lenOk = longMode;
      end
    endcase
    rangeLo = bpAddr & ~mask;
    rangeHi = rangeLo | mask;
    accHi = {1'h0, accAddr} + {{(ADDR_W+1-BYTES_W){1'h0}}, accBytes}
      - {{ADDR_W{1'h0}}, 1'h1};
    overlap = (accBytes != '0) && (accAddr <= rangeHi) &&
      (accHi >= {1'h0, rangeLo});
    hit = enabled && accValid && kindOk && lenOk && overlap;
  end

endmodule

// ### rtl/bp_event_irq.sv
`timescale 1ns/1ps
module bp_event_irq import bp_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NUM_EVT-1:0] evtPulse,
  input wire logic clrWr,
  input wire logic enWr,
  input wire logic [NUM_EVT-1:0] wrData,
  output logic [NUM_EVT-1:0] evtStatus,
  output logic [NUM_EVT-1:0] evtEnable,
  output logic irq
);

  typedef struct packed {
    logic [NUM_EVT-1:0] status;
    logic [NUM_EVT-1:0] enable;
    logic irq;
  } evt_state_t;

  evt_state_t s_r;
  evt_state_t s_nxt;

  // ----------------------------------------------------------------
  // Sticky status, set wins over clear
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (clrWr) begin
      s_nxt.status = s_r.status & ~wrData;
    end
    s_nxt.status = s_nxt.status | evtPulse;
    if (enWr) begin
      s_nxt.enable = wrData;
    end
    s_nxt.irq = |(s_nxt.status & s_nxt.enable);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign evtStatus = s_r.status;
  assign evtEnable = s_r.enable;
  assign irq = s_r.irq;

endmodule

// ### rtl/breakpoint_address_match.sv
// Contract
// - Each address register holds the breakpoint's virtual address.
// - A breakpoint matches only with its local or global enable set.
// - Task switch clears every local enable.
// - Global enables are never cleared by hardware.
// - Matches are qualified by access type and debug extensions enable.
// - Length field masks low address bits out of the compare.
// - Any accessed byte inside the range gives a match.
// - Type 00 exec, 01 write, 11 read/write, 10 I/O if enabled.
// - Length 00 one, 01 two, 11 four, 10 eight bytes long mode.
// - On a debug exception the matching hit flags are set.
// - Execution hits raise before, data and I/O hits after.
`timescale 1ns/1ps
module breakpoint_address_match import bp_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdData,
  input wire logic accValid,
  input acc_kind_t accKind,
  input wire logic [ADDR_W-1:0] accAddr,
  input wire logic [BYTES_W-1:0] accBytes,
  input wire logic taskSwitch,
  output logic dbgExcReq,
  output logic dbgExcBefore,
  output logic [NUM_BP-1:0] dbgExcHits,
  output logic irq
);

  typedef struct packed {
    logic [NUM_BP-1:0][ADDR_W-1:0] bpAddr;
    logic [DATA_W-1:0] ctrl;
    logic [NUM_BP-1:0] hitFlag;
    logic debugExtEn;
    logic longMode;
    logic [DATA_W-1:0] rdData;
    logic excReq;
    logic excBefore;
    logic [NUM_BP-1:0] excHits;
  } main_state_t;

  main_state_t s_r;
  main_state_t s_nxt;

  logic [NUM_BP-1:0] hitVec;
  logic [NUM_EVT-1:0] evtPulse;
  logic [NUM_EVT-1:0] evtStatus;
  logic [NUM_EVT-1:0] evtEnable;
  logic evtClrWr;
  logic evtEnWr;
  logic irqInt;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [REG_AW-1:0] addrOfs(input int idx,
                                                input logic hi);
    logic [REG_AW-1:0] base;
    base = OFS_ADDR_BASE + REG_AW'(idx) * OFS_ADDR_STEP;
    addrOfs = hi ? (base + OFS_ADDR_HI) : base;
  endfunction

  function automatic logic [1:0] ctrlField(input logic [DATA_W-1:0] c,
                                           input int idx,
                                           input int pos);
    ctrlField = c[pos + CTRL_FIELD_STEP * idx +: 2];
  endfunction

  function automatic logic bpEnabled(input logic [DATA_W-1:0] c,
                                     input int idx);
    bpEnabled = c[CTRL_LOC_POS + CTRL_EN_STEP * idx] |
      c[CTRL_GLB_POS + CTRL_EN_STEP * idx];
  endfunction

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  // Parallel comparators
  for (genvar g = 0; g < NUM_BP; g++) begin : gen_cmp
    bp_comparator u_cmp (
      .enabled(bpEnabled(s_r.ctrl, g)),
      .bpAddr(s_r.bpAddr[g]),
      .accessType(ctrlField(s_r.ctrl, g, CTRL_TYPE_POS)),
      .matchLength(ctrlField(s_r.ctrl, g, CTRL_LEN_POS)),
      .debugExtEn(s_r.debugExtEn),
      .longMode(s_r.longMode),
      .accValid(accValid),
      .accKind(accKind),
      .accAddr(accAddr),
      .accBytes(accBytes),
      .hit(hitVec[g])
    );
  end

  // ----------------------------------------------------------------
  // Event and interrupt block
  // ----------------------------------------------------------------
  always_comb begin
    evtPulse = '0;
    evtPulse[EVT_BREAK] = |hitVec;
    evtPulse[EVT_TASKSW] = taskSwitch;
    evtClrWr = regWr && (regAddr == OFS_EVT_CLR);
    evtEnWr = regWr && (regAddr == OFS_EVT_EN);
  end

  bp_event_irq u_evt (
    .clk(clk),
    .rst_n(rst_n),
    .evtPulse(evtPulse),
    .clrWr(evtClrWr),
    .enWr(evtEnWr),
    .wrData(regWrData[NUM_EVT-1:0]),
    .evtStatus(evtStatus),
    .evtEnable(evtEnable),
    .irq(irqInt)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // Address register writes
    for (int i = 0; i < NUM_BP; i++) begin
      if (regWr && regAddr == addrOfs(i, 1'h0)) begin
        s_nxt.bpAddr[i][DATA_W-1:0] = regWrData;
      end
      if (regWr && regAddr == addrOfs(i, 1'h1)) begin
        s_nxt.bpAddr[i][ADDR_W-1:DATA_W] = regWrData;
      end
    end

    // Control and mode writes
    if (regWr && regAddr == OFS_CTRL) begin
      s_nxt.ctrl = regWrData & CTRL_WMASK;
    end
    if (regWr && regAddr == OFS_MODE) begin
      s_nxt.debugExtEn = regWrData[MODE_DE_BIT];
      s_nxt.longMode = regWrData[MODE_LM_BIT];
    end

    if (taskSwitch) begin
      for (int i = 0; i < NUM_BP; i++) begin
        s_nxt.ctrl[CTRL_LOC_POS + CTRL_EN_STEP * i] = 1'h0;
      end
    end

    // Status write, hardware set wins
    if (regWr && regAddr == OFS_STAT) begin
      s_nxt.hitFlag = regWrData[NUM_BP-1:0];
    end
    s_nxt.hitFlag = s_nxt.hitFlag | hitVec;

    s_nxt.excReq = |hitVec;
    s_nxt.excHits = hitVec;
    s_nxt.excBefore = (|hitVec) && (accKind == ACC_EXEC);

    // Read data, valid the cycle after the strobe
    s_nxt.rdData = '0;
    if (regRd) begin
      for (int i = 0; i < NUM_BP; i++) begin
        if (regAddr == addrOfs(i, 1'h0)) begin
          s_nxt.rdData = s_r.bpAddr[i][DATA_W-1:0];
        end
        if (regAddr == addrOfs(i, 1'h1)) begin
          s_nxt.rdData = s_r.bpAddr[i][ADDR_W-1:DATA_W];
        end
      end
      if (regAddr == OFS_CTRL) begin
        s_nxt.rdData = s_r.ctrl;
      end
      if (regAddr == OFS_STAT) begin
        s_nxt.rdData[NUM_BP-1:0] = s_r.hitFlag;
      end
      if (regAddr == OFS_MODE) begin
        s_nxt.rdData[MODE_DE_BIT] = s_r.debugExtEn;
        s_nxt.rdData[MODE_LM_BIT] = s_r.longMode;
      end
      if (regAddr == OFS_EVT_STAT) begin
        s_nxt.rdData[NUM_EVT-1:0] = evtStatus;
      end
      if (regAddr == OFS_EVT_EN) begin
        s_nxt.rdData[NUM_EVT-1:0] = evtEnable;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RESET;
      for (int i = 0; i < NUM_BP; i++) begin
        s_r.bpAddr[i] <= ADDR_RESET;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdData = s_r.rdData;
  assign dbgExcReq = s_r.excReq;
  assign dbgExcBefore = s_r.excBefore;
  assign dbgExcHits = s_r.excHits;
  assign irq = irqInt;

endmodule

// ### shared/bp_pkg.sv
package bp_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_BP = 4;
  localparam int ADDR_W = 64;
  localparam int DATA_W = 32;
  localparam int REG_AW = 8;
  localparam int BYTES_W = 4;
  localparam int NUM_EVT = 2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [REG_AW-1:0] OFS_ADDR_BASE = 8'h00;
  localparam logic [REG_AW-1:0] OFS_ADDR_STEP = 8'h08;
  localparam logic [REG_AW-1:0] OFS_ADDR_HI = 8'h04;
  localparam logic [REG_AW-1:0] OFS_CTRL = 8'h20;
  localparam logic [REG_AW-1:0] OFS_STAT = 8'h24;
  localparam logic [REG_AW-1:0] OFS_MODE = 8'h28;
  localparam logic [REG_AW-1:0] OFS_EVT_STAT = 8'h2c;
  localparam logic [REG_AW-1:0] OFS_EVT_CLR = 8'h30;
  localparam logic [REG_AW-1:0] OFS_EVT_EN = 8'h34;

  // ----------------------------------------------------------------
  // Control register layout
  // ----------------------------------------------------------------
  localparam int CTRL_LOC_POS = 0;
  localparam int CTRL_GLB_POS = 1;
  localparam int CTRL_EN_STEP = 2;
  localparam int CTRL_TYPE_POS = 16;
  localparam int CTRL_LEN_POS = 18;
  localparam int CTRL_FIELD_STEP = 4;
  localparam logic [DATA_W-1:0] CTRL_WMASK = 32'hffff00ff;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 64'h0;

  // ----------------------------------------------------------------
  // Mode register bits
  // ----------------------------------------------------------------
  localparam int MODE_DE_BIT = 0;
  localparam int MODE_LM_BIT = 1;

  // ----------------------------------------------------------------
  // Event bits
  // ----------------------------------------------------------------
  localparam int EVT_BREAK = 0;
  localparam int EVT_TASKSW = 1;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] TYPE_EXEC = 2'h0;
  localparam logic [1:0] TYPE_WRITE = 2'h1;
  localparam logic [1:0] TYPE_IO = 2'h2;
  localparam logic [1:0] TYPE_RW = 2'h3;
  localparam logic [1:0] LEN_1 = 2'h0;
  localparam logic [1:0] LEN_2 = 2'h1;
  localparam logic [1:0] LEN_8 = 2'h2;
  localparam logic [1:0] LEN_4 = 2'h3;
  localparam logic [ADDR_W-1:0] MASK_1 = 64'h0;
  localparam logic [ADDR_W-1:0] MASK_2 = 64'h1;
  localparam logic [ADDR_W-1:0] MASK_4 = 64'h3;
  localparam logic [ADDR_W-1:0] MASK_8 = 64'h7;

  typedef enum logic [2:0] {
    ACC_EXEC,
    ACC_MEM_READ,
    ACC_MEM_WRITE,
    ACC_IO_READ,
    ACC_IO_WRITE
  } acc_kind_t;

endpackage
